// ===== shared/rasp_consts.svh
/*
  Constants for the request-phase capture and parity checker.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef RASP_CONSTS_SVH
`define RASP_CONSTS_SVH
`define RASP_ADDR_MSB 35
`define RASP_ADDR_LSB 3
`define RASP_LOW_MSB 16
`define RASP_HIGH_LSB 17
`define RASP_SWAP_LSB 24
`define RASP_REQ_W 5
`define RASP_SYNC_STAGES 2
`endif

// ===== shared/rasp_pkg.sv
/*
  Types for the request-phase capture block.
  Assumes rasp_consts.svh is on the include path.
*/
`include "rasp_consts.svh"
package rasp_pkg;
  typedef struct packed {
    logic [`RASP_ADDR_MSB:`RASP_ADDR_LSB] addr_n;
    logic [`RASP_REQ_W-1:0] req_n;
  } rasp_half_t;
  typedef struct packed {
    logic [`RASP_ADDR_MSB:`RASP_ADDR_LSB] addr_n;
    logic [`RASP_ADDR_MSB:`RASP_ADDR_LSB] type_n;
    logic [`RASP_REQ_W-1:0] req_a_n;
    logic [`RASP_REQ_W-1:0] req_b_n;
    logic [1:0] parity_err;
  } rasp_req_t;
  typedef enum logic [1:0] {RASP_IDLE, RASP_SUB1, RASP_SUB2} rasp_state_t;
endpackage

// ===== verilog/rasp_sync.sv
/*
  Two-flop synchroniser with edge outputs, one per pin bit.
  Assumes async pins and one clock.
*/
`timescale 1ns/1ps
module rasp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // widths below one cannot be served
  if (W < 1) begin : g_bad_width
    $error("rasp_sync width must be at least one");
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign q_o = s2_reg;
  assign rise_o = s2_reg & ~s3_reg;
  assign fall_o = ~s2_reg & s3_reg;
endmodule

// ===== verilog/rasp_top.sv
/*
  Request-phase receiver: samples the request lines on both edges of the
  two source-synchronous strobes, checks both parity bits per sub-phase.
  Assumes strobe edges are many system clocks apart (link period 125 ns)
  and that data is stable over the sync delay around each strobe edge.
*/
`timescale 1ns/1ps
`include "rasp_consts.svh"
module rasp_top import rasp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic [1:0] source_sync_address_strobes_n_i,
  input wire logic [`RASP_ADDR_MSB:`RASP_ADDR_LSB] addr_n_i,
  input wire logic [`RASP_REQ_W-1:0] req_n_i,
  input wire logic [1:0] request_parity_pair_n_i,
  output rasp_req_t req_o,
  output logic req_valid_o,
  output logic parity_err_o
);
  localparam int AW = `RASP_ADDR_MSB - `RASP_ADDR_LSB + 1;
  localparam int SW = `RASP_ADDR_MSB - `RASP_SWAP_LSB + 1;
  localparam int LW = `RASP_SWAP_LSB - `RASP_ADDR_LSB;
  localparam int DW = AW + `RASP_REQ_W + 2;

  // data and parity pins synchronised along with strobes so they line up
  logic [DW-1:0] pins_q;
  logic [1:0] stb_rise;
  logic [1:0] stb_fall;
  logic avs_fall;

  rasp_sync #(.W(DW)) u_data (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({request_parity_pair_n_i, req_n_i, addr_n_i}),
    .q_o(pins_q),
    .rise_o(),
    .fall_o()
  );
  rasp_sync #(.W(2)) u_stb (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(source_sync_address_strobes_n_i),
    .q_o(),
    .rise_o(stb_rise),
    .fall_o(stb_fall)
  );
  rasp_sync #(.W(1)) u_avs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(address_valid_strobe_n_i),
    .q_o(),
    .rise_o(),
    .fall_o(avs_fall)
  );

  wire [AW-1:0] addr_s = pins_q[AW-1:0];
  wire [`RASP_REQ_W-1:0] req_s = pins_q[AW+`RASP_REQ_W-1:AW];
  wire [1:0] par_s = pins_q[DW-1:DW-2];

  // low strobe carries request lines and lower group, high strobe the upper group
  wire low_edge = stb_rise[0] | stb_fall[0];
  wire high_edge = stb_rise[1] | stb_fall[1];
  wire first_half_low = stb_fall[0];
  wire first_half_high = stb_fall[1];
  localparam int LOWN = `RASP_LOW_MSB - `RASP_ADDR_LSB + 1;

  rasp_state_t state_reg, state_next;
  logic [AW-1:0] addr_reg, type_reg;
  logic [`RASP_REQ_W-1:0] req_a_reg, req_b_reg;
  logic [1:0] par1_reg;
  logic [1:0] got_reg;
  logic done_reg;
  rasp_req_t out_reg;
  logic valid_reg, err_reg;

  // inverted (high-active count) xor: even number low gives high parity
  function automatic logic even_low(input logic [AW+`RASP_REQ_W-1:0] v);
    even_low = ~^(~v);
  endfunction

  // sub-phase 1: upper bits on parity 0, lower on parity 1; swapped in 2
  function automatic logic [1:0] calc_par(input logic [AW-1:0] a,
                                          input logic [`RASP_REQ_W-1:0] r,
                                          input logic second);
    logic [AW+`RASP_REQ_W-1:0] up;
    logic [AW+`RASP_REQ_W-1:0] lo;
    up = '1;
    lo = '1;
    up[SW-1:0] = a[AW-1:LW];
    lo[LW+`RASP_REQ_W-1:0] = {r, a[LW-1:0]};
    if (second) begin
      calc_par = {even_low(up), even_low(lo)};
    end else begin
      calc_par = {even_low(lo), even_low(up)};
    end
  endfunction

  wire [1:0] par_exp1 = calc_par(addr_reg, req_a_reg, 1'b0);
  wire [1:0] par_exp2 = calc_par(type_reg, req_b_reg, 1'b1);
  wire [1:0] par_err = (par1_reg ^ par_exp1) | (par_s ^ par_exp2);
  wire both_second = (got_reg == 2'b11);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RASP_IDLE: begin
        if (avs_fall) begin
          state_next = RASP_SUB1;
        end
      end
      RASP_SUB1: begin
        if (both_second) begin
          state_next = RASP_SUB2;
        end
      end
      RASP_SUB2: begin
        if (both_second) begin
          state_next = RASP_IDLE;
        end
      end
      default: state_next = RASP_IDLE;
    endcase
  end

  // got_reg: which strobe groups have shown their edge in this sub-phase
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= RASP_IDLE;
      addr_reg <= '1;
      type_reg <= '1;
      req_a_reg <= '1;
      req_b_reg <= '1;
      par1_reg <= '1;
      got_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      done_reg <= (state_reg == RASP_SUB2) && both_second;
      if (state_reg == RASP_IDLE || both_second) begin
        got_reg <= '0;
      end else begin
        // sub-phase 1 takes the falling edges, sub-phase 2 the rising
        if ((state_reg == RASP_SUB1 && first_half_low) ||
            (state_reg == RASP_SUB2 && stb_rise[0])) begin
          got_reg[0] <= 1'b1;
        end
        if ((state_reg == RASP_SUB1 && first_half_high) ||
            (state_reg == RASP_SUB2 && stb_rise[1])) begin
          got_reg[1] <= 1'b1;
        end
      end
      if (state_reg == RASP_SUB1 && low_edge) begin
        addr_reg[LOWN-1:0] <= addr_s[LOWN-1:0];
        req_a_reg <= req_s;
        par1_reg <= par_s;
      end
      if (state_reg == RASP_SUB1 && high_edge) begin
        addr_reg[AW-1:LOWN] <= addr_s[AW-1:LOWN];
      end
      if (state_reg == RASP_SUB2 && low_edge) begin
        type_reg[LOWN-1:0] <= addr_s[LOWN-1:0];
        req_b_reg <= req_s;
      end
      if (state_reg == RASP_SUB2 && high_edge) begin
        type_reg[AW-1:LOWN] <= addr_s[AW-1:LOWN];
      end
    end
  end

  // parity of sub-phase 2 read from pins two cycles after the last edge is seen
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg <= '0;
      valid_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (ce_i) begin
      valid_reg <= done_reg;
      if (done_reg) begin
        out_reg.addr_n <= addr_reg;
        out_reg.type_n <= type_reg;
        out_reg.req_a_n <= req_a_reg;
        out_reg.req_b_n <= req_b_reg;
        out_reg.parity_err <= par_err;
        err_reg <= |par_err;
      end
    end
  end

  assign req_o = out_reg;
  assign req_valid_o = valid_reg;
  assign parity_err_o = err_reg;
endmodule

// ===== bench/rasp_top_properties.sv
/*
  Port checker for rasp_top, bound into every instance.
  Assumes address-valid falls before the strobes and the strobes idle high.
  Checks pause while the clock enable is low, since the block is frozen then.
*/
`timescale 1ns/1ps
`include "rasp_consts.svh"
module rasp_top_properties import rasp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic address_valid_strobe_n_i,
  input wire logic [1:0] source_sync_address_strobes_n_i,
  input wire logic [`RASP_ADDR_MSB:`RASP_ADDR_LSB] addr_n_i,
  input wire logic [`RASP_REQ_W-1:0] req_n_i,
  input wire logic [1:0] request_parity_pair_n_i,
  input wire rasp_req_t req_o,
  input wire logic req_valid_o,
  input wire logic parity_err_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_valid_one_pulse: assert property (req_valid_o |=> !req_valid_o [*8])
    else $error("valid pulse too long");
  a_strobes_high_done: assert property (req_valid_o |-> &source_sync_address_strobes_n_i)
    else $error("valid before both strobes rose");
  a_rise_to_valid: assert property ($fell(address_valid_strobe_n_i) ##[1:30]
    $rose(&source_sync_address_strobes_n_i) |-> ##[2:10] req_valid_o)
    else $error("no valid after second half");
  a_err_level_match: assert property (req_valid_o |-> parity_err_o == |req_o.parity_err)
    else $error("error flag disagrees with fields");
  a_err_holds: assert property (!req_valid_o |-> $stable(parity_err_o))
    else $error("error flag moved between requests");
  a_ads_sync_quiet: assert property ($fell(address_valid_strobe_n_i) |-> !req_valid_o [*4])
    else $error("valid too soon after address valid");
  a_fields_hold: assert property (req_valid_o |=> $stable(req_o) [*3])
    else $error("captured fields moved after valid");
  cover property (req_valid_o && parity_err_o);
  cover property (req_valid_o && !parity_err_o);
  cover property ($fell(address_valid_strobe_n_i));
endmodule
bind rasp_top rasp_top_properties chk (.clk_sys_i, .rst_i, .ce_i, .address_valid_strobe_n_i,
  .source_sync_address_strobes_n_i, .addr_n_i, .req_n_i, .request_parity_pair_n_i, .req_o,
  .req_valid_o, .parity_err_o);

// ===== bench/rasp_agent.sv
/*
  Far-side bus agent: drives one two-half request per call of send.
  Assumes pulled-up lines, so released lines read all high.
*/
`timescale 1ns/1ps
module rasp_agent (
  input wire logic clk_sys_i,
  output logic av_n_o,
  output logic [1:0] stb_n_o,
  output logic [35:3] a_n_o,
  output logic [4:0] r_n_o,
  output logic [1:0] par_n_o
);
  initial begin
    av_n_o = 1'b1;
    stb_n_o = 2'b11;
    a_n_o = '1;
    r_n_o = '1;
    par_n_o = 2'b11;
  end
  // parity high when even count of lines low
  function automatic logic [1:0] pr(input logic [35:3] a, input logic [4:0] r, input logic s);
    logic h;
    logic l;
    h = ~^(~a[35:24]);
    l = ~^(~{a[23:3], r});
    return s ? {h, l} : {l, h};
  endfunction
  // about half a link period between strobe edges
  task automatic send(input logic [35:3] a, t, input logic [4:0] ra, rb,
                      input logic [1:0] e1, e2, input logic av);
    @(negedge clk_sys_i);
    av_n_o = ~av;
    a_n_o = a;
    r_n_o = ra;
    par_n_o = pr(a, ra, 1'b0) ^ e1;
    repeat (8) @(negedge clk_sys_i);
    stb_n_o = 2'b00;
    repeat (8) @(negedge clk_sys_i);
    av_n_o = 1'b1;
    a_n_o = t;
    r_n_o = rb;
    par_n_o = pr(t, rb, 1'b1) ^ e2;
    repeat (8) @(negedge clk_sys_i);
    stb_n_o = 2'b11;
    repeat (8) @(negedge clk_sys_i);
    a_n_o = '1;
    r_n_o = '1;
    par_n_o = 2'b11;
  endtask
endmodule

// ===== bench/testbench.sv
/*
  Self-checking bench for rasp_top driven by the far-side agent.
  Assumes the agent holds each half well beyond the sync delay.
*/
`timescale 1ns/1ps
module testbench;
  import rasp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic av_n;
  logic [1:0] stb_n;
  logic [35:3] a_n;
  logic [4:0] r_n;
  logic [1:0] par_n;
  rasp_req_t req_o;
  logic req_valid_o;
  logic parity_err_o;
  int check_count = 0;
  int fail_count = 0;
  int cyc = 0;
  initial forever #2 clk_sys_i = ~clk_sys_i;
  rasp_agent agent (.clk_sys_i(clk_sys_i), .av_n_o(av_n), .stb_n_o(stb_n), .a_n_o(a_n),
    .r_n_o(r_n), .par_n_o(par_n));
  rasp_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_valid_strobe_n_i(av_n), .source_sync_address_strobes_n_i(stb_n),
    .addr_n_i(a_n), .req_n_i(r_n), .request_parity_pair_n_i(par_n), .req_o(req_o),
    .req_valid_o(req_valid_o), .parity_err_o(parity_err_o));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [35:3] a, t, input logic [4:0] ra, rb, input logic [3:0] e,
                     input logic av, output logic seen);
    seen = 1'b0;
    fork
      agent.send(a, t, ra, rb, e[1:0], e[3:2], av);
      repeat (40) begin
        @(negedge clk_sys_i);
        if (req_valid_o === 1'b1) seen = 1'b1;
      end
    join
  endtask
  // strobes without address valid must be ignored
  task automatic t_no_ads;
    logic v;
    run(33'h0, 33'h0, 5'h00, 5'h00, 4'h0, 1'b0, v);
    check(v, 1'b0);
  endtask
  task automatic t_fields;
    logic v;
    run(33'h1_2345_6789, 33'h0_0abc_def0, 5'h0a, 5'h15, 4'h0, 1'b1, v);
    check(v, 1'b1);
    check(req_o.addr_n, 33'h1_2345_6789);
    check(req_o.type_n, 33'h0_0abc_def0);
    check(req_o.req_a_n, 5'h0a);
    check(req_o.req_b_n, 5'h15);
    check(parity_err_o, 1'b0);
  endtask
  // clock enable low: a whole request passes unseen, old fields stay
  task automatic t_freeze;
    logic v;
    ce_i = 1'b0;
    run(33'h0_1111_2222, 33'h0_3333_4444, 5'h03, 5'h0c, 4'h0, 1'b1, v);
    ce_i = 1'b1;
    check(v, 1'b0);
    check(req_o.addr_n, 33'h1_2345_6789);
    check(req_o.type_n, 33'h0_0abc_def0);
  endtask
  // a[24] low in both halves makes the two bits differ, so a swap shows
  task automatic t_parity;
    logic v;
    for (int i = 0; i < 5; i++) begin
      run(33'h1_ffdf_ffff, 33'h1_ffdf_ffff, '1, '1, 4'h1 << i, 1'b1, v);
      check(v, 1'b1);
      check(parity_err_o, i < 4);
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    t_no_ads;
    t_fields;
    t_freeze;
    t_parity;
    report_and_stop;
  end
endmodule
